// [pkg/mis_pkg.sv]
package mis_pkg;
   // Register offsets in bank 0, and the one bank 1 register tracked here
   localparam logic [2:0] ADR_DATA    = 3'h0;
   localparam logic [2:0] ADR_IEN     = 3'h1;
   localparam logic [2:0] ADR_IID     = 3'h2;
   localparam logic [2:0] ADR_MCTL    = 3'h4;
   localparam logic [2:0] ADR_LSTAT   = 3'h5;
   localparam logic [2:0] ADR_MSTAT2  = 3'h6;
   localparam logic [2:0] ADR_SCRATCH = 3'h7;
   localparam logic [2:0] ADR_MSTAT1  = 3'h6;
   // Control bit positions
   localparam int MC_TERM_READY = 0;
   localparam int MC_REQ_SEND   = 1;
   localparam int MC_RESET_REQ  = 2;
   localparam int MC_IRQ_OE     = 3;
   localparam int MC_LOOP       = 4;
   localparam int MC_ADDR_SEL   = 7;
   localparam logic [7:0] MCTL_WMASK  = 8'h9F;
   localparam logic [7:0] MCTL_RST    = 8'h00;
   localparam logic [7:0] SCRATCH_RST = 8'h00;
   localparam logic [3:0] IEN_RST     = 4'h0;
   // Enable bit positions
   localparam int IE_RX    = 0;
   localparam int IE_TX_HOLDING_EMPTY  = 1;
   localparam int IE_LINE  = 2;
   localparam int IE_MSTAT = 3;
   // Identification codes, bits 3..0
   localparam logic [3:0] IID_NONE   = 4'h1;
   localparam logic [3:0] IID_LINE   = 4'h6;
   localparam logic [3:0] IID_RXDATA = 4'h4;
   localparam logic [3:0] IID_TX_HOLDING_EMPTY   = 4'h2;
   localparam logic [3:0] IID_MSTAT2 = 4'h0;
   localparam logic [3:0] IID_MSTAT1 = 4'h8;
   // Timing
   localparam longint CLK_HZ       = 50_000_000;
   localparam longint DTR_LOSS_MS  = 50;
   localparam longint DTR_LOSS_CYC = (DTR_LOSS_MS * CLK_HZ + 999) / 1000;
   typedef enum logic [1:0] {
      MIS_DTR_HIGH = 2'b00,
      MIS_DTR_WAIT = 2'b01,
      MIS_DTR_LOST = 2'b10
   } mis_dtr_state_t;
endpackage

// [pkg/mis_irq_if.sv]
`timescale 1ns/1ps
interface mis_irq_if;
   // Gated pending: 0 line, 1 rx data, 2 holding empty, 3 status 2, 4 status 1
   logic [4:0] pend;
   logic [3:0] code;
   modport ctrl (output pend, input code);
   modport prio (input pend, output code);
endinterface

// [hw/mis_irq_prio.sv]
`timescale 1ns/1ps
module mis_irq_prio
   import mis_pkg::*;
(
   mis_irq_if.prio irq
);
   function automatic logic [3:0] pick(input logic [4:0] p);
      logic [3:0] c;
      c = IID_NONE;
      if (p[0])
      begin
         c = IID_LINE;
      end
      else if (p[1])
      begin
         c = IID_RXDATA;
      end
      else if (p[2])
      begin
         c = IID_TX_HOLDING_EMPTY;
      end
      else if (p[3])
      begin
         c = IID_MSTAT2;
      end
      else if (p[4])
      begin
         c = IID_MSTAT1;
      end
      return c;
   endfunction

   assign irq.code = pick(irq.pend);
endmodule

// [hw/mis_dtr_timer.sv]
`timescale 1ns/1ps
module mis_dtr_timer
   import mis_pkg::*;
#(
   parameter int unsigned LOSS_CYC = 32'(DTR_LOSS_CYC)
)
(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // Terminal-ready level and disconnect start
   input  wire logic term_ready,
   output logic      loss_start
);
   mis_dtr_state_t state_q;
   logic [31:0]    cnt_q;

   // Fires once per low period; needs a new high to rearm
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q    <= MIS_DTR_LOST;
         cnt_q      <= 32'h0000_0000;
         loss_start <= 1'b0;
      end
      else
      begin
         loss_start <= 1'b0;
         unique case (state_q)
            MIS_DTR_HIGH:
            begin
               cnt_q <= 32'h0000_0000;
               if (!term_ready)
               begin
                  state_q <= MIS_DTR_WAIT;
               end
            end
            MIS_DTR_WAIT:
            begin
               if (term_ready)
               begin
                  state_q <= MIS_DTR_HIGH;
               end
               else if (cnt_q >= LOSS_CYC - 1)
               begin
                  state_q    <= MIS_DTR_LOST;
                  loss_start <= 1'b1;
               end
               else
               begin
                  cnt_q <= cnt_q + 32'h0000_0001;
               end
            end
            MIS_DTR_LOST:
            begin
               if (term_ready)
               begin
                  state_q <= MIS_DTR_HIGH;
               end
            end
            default:
            begin
               state_q <= MIS_DTR_LOST;
            end
         endcase
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_loss_single: assert property (loss_start |=> !loss_start)
      else $error("Disconnect start lasted more than one cycle");
   a_loss_needs_low: assert property (
      loss_start |-> !term_ready && $past(state_q) == MIS_DTR_WAIT)
      else $error("Disconnect start without a held low level");
endmodule

// [hw/mis_top.sv]
`timescale 1ns/1ps
module mis_top
   import mis_pkg::*;
#(
   parameter int unsigned DTR_LOSS_CYCLES = 32'(DTR_LOSS_CYC)
)
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Host register bus
   input  wire logic       cs_n,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic            data_oe,
   // Neighbouring serial registers
   input  wire logic [7:0] ext_rdata,
   output logic            ext_rd_stb,
   output logic            ext_wr_stb,
   output logic            ext_bank,
   // Interrupt sources
   input  wire logic       line_cond_evt,
   input  wire logic       rx_data_evt,
   input  wire logic       thr_empty_evt,
   input  wire logic       msr1_evt,
   // Modem indications
   input  wire logic       handshake_done,
   input  wire logic       powered_up,
   input  wire logic       ring_n,
   input  wire logic       carrier_valid,
   input  wire logic       call_prog_tone,
   input  wire logic       call_prog_en,
   // Control outputs
   output logic            terminal_ready,
   output logic            master_reset,
   output logic            loopback,
   output logic            dtr_loss_start,
   // Interrupt pin
   output logic            interrupt_output,
   output logic            interrupt_output_oe
);
   logic       rd_q;
   logic       wr_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [3:0] ien_q;
   logic [7:0] mctl_q;
   logic [7:0] scratch_q;
   logic [3:0] iir_q;
   logic       line_q;
   logic       rxd_q;
   logic       tx_holding_empty_q;
   logic       ms1_q;
   logic [3:0] live;
   logic [3:0] live_q;
   logic [3:0] chg;
   logic [3:0] mdelta_q;
   logic       bus_rd;
   logic       bus_wr;
   logic       rd_stb;
   logic       wr_stb;
   logic       bank;
   logic       own_sel;
   logic       iid_sel;
   logic       rd_lstat;
   logic       rd_data;
   logic       wr_data;
   logic       rd_iid;
   logic       rd_ms2;
   logic       rd_ms1;
   logic       reset_req;

   mis_irq_if irq ();

   function automatic logic hit(input logic [2:0] a, input logic b,
                                input logic [2:0] off, input logic ob);
      return (a == off) && (b == ob);
   endfunction

   // Hardware set beats software clear in the same cycle
   function automatic logic sticky(input logic q, input logic set, input logic clr);
      return set | (q & ~clr);
   endfunction

   assign bank      = mctl_q[MC_ADDR_SEL];
   assign reset_req = mctl_q[MC_RESET_REQ];
   assign bus_rd    = ~cs_n & ~rd_n;
   assign bus_wr    = ~cs_n & ~wr_n;
   assign rd_stb    = bus_rd & ~rd_q;
   assign wr_stb    = bus_wr & ~wr_q;
   assign iid_sel   = ~cs_n & hit(addr, bank, ADR_IID, 1'b0);
   assign own_sel   = hit(addr, bank, ADR_IEN, 1'b0) | hit(addr, bank, ADR_IID, 1'b0)
                    | hit(addr, bank, ADR_MSTAT2, 1'b0) | hit(addr, bank, ADR_SCRATCH, 1'b0)
                    | (addr == ADR_MCTL);
   assign rd_lstat  = rd_stb & hit(addr, bank, ADR_LSTAT, 1'b0);
   assign rd_data   = rd_stb & hit(addr, bank, ADR_DATA, 1'b0);
   assign wr_data   = wr_stb & hit(addr, bank, ADR_DATA, 1'b0);
   assign rd_iid    = rd_stb & hit(addr, bank, ADR_IID, 1'b0);
   assign rd_ms2    = rd_stb & hit(addr, bank, ADR_MSTAT2, 1'b0);
   assign rd_ms1    = rd_stb & hit(addr, bank, ADR_MSTAT1, 1'b1);

   // Strobes for registers that live in the serial section
   assign ext_rd_stb = rd_stb & ~own_sel;
   assign ext_wr_stb = wr_stb & ~own_sel;
   assign ext_bank   = bank;

   assign data_oe  = bus_rd;
   assign data_out = rdata_q;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
      end
      else
      begin
         rd_q <= bus_rd;
         wr_q <= bus_wr;
      end
   end

   // Read mux; a read is sampled once at the start of the strobe
   always_comb
   begin
      rdata_d = ext_rdata;
      if (addr == ADR_MCTL)
      begin
         rdata_d = mctl_q & MCTL_WMASK;
      end
      else if (!bank)
      begin
         case (addr)
            ADR_IEN:     rdata_d = {4'h0, ien_q};
            ADR_IID:     rdata_d = {4'h0, iir_q};
            ADR_MSTAT2:  rdata_d = {live_q[3], live_q[2], live_q[1], live_q[0], mdelta_q};
            ADR_SCRATCH: rdata_d = scratch_q;
            default:     rdata_d = ext_rdata;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rdata_q <= 8'h00;
      end
      else if (rd_stb)
      begin
         rdata_q <= rdata_d;
      end
   end

   // Control register; bank select stays reachable in both banks
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         mctl_q <= MCTL_RST;
      end
      else if (wr_stb && addr == ADR_MCTL)
      begin
         mctl_q <= data_in & MCTL_WMASK;
      end
   end

   // Enables and scratch fall back to reset under the reset request
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         ien_q     <= IEN_RST;
         scratch_q <= SCRATCH_RST;
      end
      else if (reset_req)
      begin
         ien_q     <= IEN_RST;
         scratch_q <= SCRATCH_RST;
      end
      else if (wr_stb && !bank)
      begin
         if (addr == ADR_IEN)
         begin
            ien_q <= data_in[3:0];
         end
         if (addr == ADR_SCRATCH)
         begin
            scratch_q <= data_in;
         end
      end
   end

   assign terminal_ready      = mctl_q[MC_TERM_READY];
   assign master_reset        = reset_req;
   assign loopback            = mctl_q[MC_LOOP];
   assign interrupt_output_oe = mctl_q[MC_IRQ_OE];

   mis_dtr_timer #(
      .LOSS_CYC (DTR_LOSS_CYCLES)
   ) u_dtr (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .term_ready (mctl_q[MC_TERM_READY]),
      .loss_start (dtr_loss_start)
   );

   // Interrupt sources held until their clearing access
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         line_q <= 1'b0;
         rxd_q  <= 1'b0;
         tx_holding_empty_q <= 1'b0;
         ms1_q  <= 1'b0;
      end
      else
      begin
         line_q <= sticky(line_q, line_cond_evt, rd_lstat | reset_req);
         rxd_q  <= sticky(rxd_q, rx_data_evt, rd_data | reset_req);
         tx_holding_empty_q <= sticky(tx_holding_empty_q, thr_empty_evt,
                          wr_data | (rd_iid && iir_q == IID_TX_HOLDING_EMPTY) | reset_req);
         ms1_q  <= sticky(ms1_q, msr1_evt, rd_ms1 | reset_req);
      end
   end

   // Live modem lines, replaced by control bits in loopback
   always_comb
   begin
      if (mctl_q[MC_LOOP])
      begin
         live = {mctl_q[MC_IRQ_OE], mctl_q[MC_RESET_REQ],
                 mctl_q[MC_TERM_READY], mctl_q[MC_REQ_SEND]};
      end
      else
      begin
         live = {call_prog_en ? call_prog_tone : carrier_valid,
                 ~ring_n, powered_up, handshake_done};
      end
   end

   // Ring flags only the end of ringing, not its start
   assign chg = {live[3] ^ live_q[3], live_q[2] & ~live[2],
                 live[1] ^ live_q[1], live[0] ^ live_q[0]};

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         live_q   <= 4'h0;
         mdelta_q <= 4'h0;
      end
      else
      begin
         live_q <= live;
         for (int i = 0; i < 4; i++)
         begin
            mdelta_q[i] <= sticky(mdelta_q[i], chg[i], rd_ms2);
         end
      end
   end

   // Status registers keep running while every enable is off
   assign irq.pend = {ms1_q & ien_q[IE_MSTAT], (|mdelta_q) & ien_q[IE_MSTAT],
                      tx_holding_empty_q & ien_q[IE_TX_HOLDING_EMPTY], rxd_q & ien_q[IE_RX],
                      line_q & ien_q[IE_LINE]};

   mis_irq_prio u_prio (
      .irq (irq)
   );

   // Code is frozen while the host addresses it, so a pending read
   // cannot see the source change underneath it
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         iir_q <= IID_NONE;
      end
      else if (!iid_sel)
      begin
         iir_q <= irq.code;
      end
   end

   assign interrupt_output = ~iir_q[0];

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_iid_hold;
      iid_sel ##1 iid_sel;
   endsequence

   sequence s_ring_end;
      live_q[2] ##1 !live_q[2];
   endsequence

   a_iid_frozen: assert property (s_iid_hold |-> $stable(iir_q))
      else $error("Identification code moved while addressed");
   a_iid_upper: assert property (
      rd_iid |=> data_out[7:4] == 4'h0 && data_out[3:0] == $past(iir_q))
      else $error("Identification read returned a wrong byte");
   a_line_first: assert property (irq.pend[0] && !iid_sel |=> iir_q == IID_LINE)
      else $error("Line condition not reported first");
   a_rx_second: assert property (
      irq.pend[1] && !irq.pend[0] && !iid_sel |=> iir_q == IID_RXDATA)
      else $error("Received data not reported second");
   a_none_disabled: assert property (
      ien_q == 4'h0 && !iid_sel |=> iir_q == IID_NONE && !interrupt_output)
      else $error("Interrupt reported with all enables clear");
   a_tx_holding_empty_clear: assert property (wr_data && !thr_empty_evt |=> !tx_holding_empty_q)
      else $error("Holding-empty not cleared by a data write");
   a_ms2_clear: assert property (rd_ms2 && chg == 4'h0 |=> mdelta_q == 4'h0)
      else $error("Status read left delta bits set");
   a_ring_flag: assert property (s_ring_end |-> mdelta_q[2] || $past(rd_ms2))
      else $error("Ring trailing edge not flagged");
   a_oe_write: assert property (
      wr_stb && addr == ADR_MCTL |=> interrupt_output_oe == $past(data_in[3]))
      else $error("Interrupt pin enable does not follow control write");
   a_mctl_rsvd: assert property (rd_stb && addr == ADR_MCTL |=> data_out[6:5] == 2'b00)
      else $error("Control bits 5 and 6 not read as zero");
   a_scratch_keep: assert property (
      wr_stb && !bank && addr == ADR_SCRATCH && !reset_req |=> scratch_q == $past(data_in))
      else $error("Scratch register lost the written byte");
endmodule

// [tb/mis_host_model.sv]
`timescale 1ns/1ps
module mis_host_model
(
   // Clock
   input  wire logic       sys_clk,
   // Bus pins driven by the host
   output logic            cs_n,
   output logic            rd_n,
   output logic            wr_n,
   output logic [2:0]      addr,
   output logic [7:0]      data_in,
   // Device answer
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe,
   // Finished read
   output logic            rd_done,
   output logic [7:0]      rd_data
);
   initial
   begin
      {cs_n, rd_n, wr_n, rd_done} = 4'hE;
      addr    = 3'h0;
      data_in = 8'h00;
      rd_data = 8'h00;
   end

   // Strobes rise two cycles before the next access, so no take is missed
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      {cs_n, wr_n} = 2'b00;
      addr         = a;
      data_in      = d;
      @(negedge sys_clk);
      {cs_n, wr_n} = 2'b11;
      data_in      = ~d;
      @(negedge sys_clk);
   endtask

   // Data pins count only while the device drives them
   task automatic rd(input logic [2:0] a);
      @(negedge sys_clk);
      {cs_n, rd_n} = 2'b00;
      addr         = a;
      @(negedge sys_clk);
      rd_data      = (data_oe === 1'b1) ? data_out : 8'hzz;
      {cs_n, rd_n} = 2'b11;
      rd_done      = 1'b1;
      @(negedge sys_clk);
      rd_done      = 1'b0;
   endtask
endmodule

// [tb/test_modem_interrupt_and_status.sv]
`timescale 1ns/1ps
module test_modem_interrupt_and_status;
   import mis_pkg::*;
   localparam int unsigned LOSS = 20;
   typedef struct {string what; logic [7:0] exp; logic [7:0] mask;} mis_note_t;
   logic       sys_clk, rst, cs_n, rd_n, wr_n, data_oe, rd_done;
   logic [2:0] addr;
   logic [7:0] data_in, data_out, rd_data, ext_rdata;
   logic       ext_rd_stb, ext_wr_stb, ext_bank, terminal_ready, master_reset, loopback;
   logic       dtr_loss_start, interrupt_output, interrupt_output_oe;
   logic       line_cond_evt, rx_data_evt, thr_empty_evt, msr1_evt;
   logic       handshake_done, powered_up, ring_n, carrier_valid, call_prog_tone, call_prog_en;
   logic [31:0] seed = 32'h81801d2d;
   int          fails = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          n_erd = 0;
   int          n_ewr = 0;
   int          n;
   mis_note_t   notes[$];
   mis_note_t   cur;
   logic [3:0]  codes [4] = '{IID_RXDATA, IID_TX_HOLDING_EMPTY, IID_LINE, IID_MSTAT2};

   mis_top #(.DTR_LOSS_CYCLES(LOSS)) u_mis_top (
      .sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .ext_rdata(ext_rdata),
      .ext_rd_stb(ext_rd_stb), .ext_wr_stb(ext_wr_stb), .ext_bank(ext_bank),
      .line_cond_evt(line_cond_evt), .rx_data_evt(rx_data_evt),
      .thr_empty_evt(thr_empty_evt), .msr1_evt(msr1_evt), .handshake_done(handshake_done),
      .powered_up(powered_up), .ring_n(ring_n), .carrier_valid(carrier_valid),
      .call_prog_tone(call_prog_tone), .call_prog_en(call_prog_en),
      .terminal_ready(terminal_ready), .master_reset(master_reset), .loopback(loopback),
      .dtr_loss_start(dtr_loss_start), .interrupt_output(interrupt_output),
      .interrupt_output_oe(interrupt_output_oe));

   mis_host_model u_mis_host_model (
      .sys_clk(sys_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .rd_done(rd_done), .rd_data(rd_data));

   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      u_mis_host_model.wr(a, d);
   endtask

   // A zero mask only clears on read; the result is not judged
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m,
                     input string what);
      notes.push_back('{what, e, m});
      u_mis_host_model.rd(a);
   endtask

   task automatic rdx(input logic [2:0] a, input string what);
      ext_rdata = rnd();
      rd(a, ext_rdata, 8'hFF, what);
   endtask

   task automatic idle(input int k);
      repeat (k) @(negedge sys_clk);
   endtask

   task automatic pulse_all();
      @(negedge sys_clk);
      {line_cond_evt, rx_data_evt, thr_empty_evt, msr1_evt} = 4'hF;
      handshake_done = ~handshake_done;
      @(negedge sys_clk);
      {line_cond_evt, rx_data_evt, thr_empty_evt, msr1_evt} = 4'h0;
      idle(3);
   endtask

   task automatic clear_all(input logic [7:0] ctl);
      wr(ADR_IEN, 8'h00);
      rd(ADR_LSTAT, 8'h00, 8'h00, "");
      rd(ADR_DATA, 8'h00, 8'h00, "");
      rd(ADR_MSTAT2, 8'h00, 8'h00, "");
      wr(ADR_DATA, rnd());
      wr(ADR_MCTL, ctl | 8'h80);
      rd(ADR_MSTAT1, 8'h00, 8'h00, "");
      wr(ADR_MCTL, ctl);
   endtask

   always @(posedge rd_done)
   begin
      if (notes.size() == 0)
         chk("unexpected read", 8'h00, 8'hFF);
      else
      begin
         cur = notes.pop_front();
         if (cur.mask != 8'h00)
            chk(cur.what, cur.exp & cur.mask, rd_data & cur.mask);
      end
   end

   always @(posedge sys_clk)
   begin
      cyc++;
      if (ext_rd_stb === 1'b1)
         n_erd++;
      if (ext_wr_stb === 1'b1)
         n_ewr++;
      if (cyc == 4000)
      begin
         fails++;
         report_and_stop();
      end
   end

   initial
   begin
      rst = 1'b1;
      ext_rdata = 8'h00;
      {line_cond_evt, rx_data_evt, thr_empty_evt, msr1_evt} = 4'h0;
      {handshake_done, powered_up, ring_n, carrier_valid} = 4'b0110;
      {call_prog_tone, call_prog_en} = 2'b00;
      idle(20);
      rst = 1'b0;
      rd(ADR_MCTL, MCTL_RST, 8'hFF, "control");
      rd(ADR_IEN, {4'h0, IEN_RST}, 8'hFF, "enable");
      rd(ADR_IID, {4'h0, IID_NONE}, 8'hFF, "ident idle");
      chk("irq oe", 8'h00, {7'h0, interrupt_output_oe});
      rd(ADR_MSTAT2, 8'h00, 8'h00, "");
      for (int i = 0; i < 4; i++)
      begin
         cur.exp = rnd();
         wr(ADR_SCRATCH, cur.exp);
         rd(ADR_SCRATCH, cur.exp, 8'hFF, "scratch");
      end
      wr(ADR_MCTL, 8'h6A);
      rd(ADR_MCTL, 8'h0A, 8'hFF, "control bits");
      chk("irq oe", 8'h01, {7'h0, interrupt_output_oe});
      chk("loop/reset", 8'h00, {6'h0, loopback, master_reset});
      rdx(3'h3, "external");
      wr(ADR_MCTL, 8'h8A);
      chk("bank", 8'h01, {7'h0, ext_bank});
      rdx(ADR_MSTAT1, "bank1 status");
      wr(ADR_MCTL, 8'h0A);
      wr(ADR_IID, 8'hFF);
      rd(ADR_IID, {4'h0, IID_NONE}, 8'hFF, "ident read only");
      // All five sources at once, serviced in priority order
      wr(ADR_IEN, 8'h0F);
      pulse_all();
      chk("irq pin", 8'h01, {7'h0, interrupt_output});
      rd(ADR_IID, {4'h0, IID_LINE}, 8'hFF, "ident line");
      rdx(ADR_LSTAT, "line status");
      rd(ADR_IID, {4'h0, IID_RXDATA}, 8'hFF, "ident rx");
      rdx(ADR_DATA, "rx data");
      rd(ADR_IID, {4'h0, IID_TX_HOLDING_EMPTY}, 8'hFF, "ident tx_holding_empty");
      rd(ADR_IID, {4'h0, IID_MSTAT2}, 8'hFF, "ident status2");
      rd(ADR_MSTAT2, 8'h31, 8'hFF, "status2 cts");
      rd(ADR_IID, {4'h0, IID_MSTAT1}, 8'hFF, "ident status1");
      wr(ADR_MCTL, 8'h8A);
      rdx(ADR_MSTAT1, "status1");
      wr(ADR_MCTL, 8'h0A);
      rd(ADR_IID, {4'h0, IID_NONE}, 8'hFF, "ident drained");
      idle(2);
      chk("irq pin low", 8'h00, {7'h0, interrupt_output});
      @(negedge sys_clk) thr_empty_evt = 1'b1;
      @(negedge sys_clk) thr_empty_evt = 1'b0;
      idle(2);
      wr(ADR_DATA, rnd());
      rd(ADR_IID, {4'h0, IID_NONE}, 8'hFF, "tx_holding_empty write clear");
      clear_all(8'h0A);
      for (int i = 0; i < 4; i++)
      begin
         wr(ADR_IEN, 8'h01 << i);
         pulse_all();
         rd(ADR_IID, {4'h0, codes[i]}, 8'hFF, "single enable");
         clear_all(8'h0A);
      end
      // Enables clear: pin and code stay quiet, status still moves
      @(negedge sys_clk) rx_data_evt = 1'b1;
      @(negedge sys_clk) rx_data_evt = 1'b0;
      handshake_done = 1'b0;
      idle(3);
      rd(ADR_IID, {4'h0, IID_NONE}, 8'hFF, "ident disabled");
      chk("irq pin off", 8'h00, {7'h0, interrupt_output});
      rd(ADR_MSTAT2, 8'h21, 8'hFF, "status2 disabled");
      powered_up = 1'b0;
      carrier_valid = 1'b1;
      idle(3);
      rd(ADR_MSTAT2, 8'h8A, 8'hFF, "status2 dsr cd");
      rd(ADR_MSTAT2, 8'h80, 8'hFF, "status2 cleared");
      ring_n = 1'b0;
      idle(3);
      rd(ADR_MSTAT2, 8'hC0, 8'hFF, "ring on");
      ring_n = 1'b1;
      idle(3);
      rd(ADR_MSTAT2, 8'h84, 8'hFF, "ring trailing");
      call_prog_en = 1'b1;
      idle(3);
      rd(ADR_MSTAT2, 8'h08, 8'hFF, "tone select");
      call_prog_tone = 1'b1;
      idle(3);
      rd(ADR_MSTAT2, 8'h88, 8'hFF, "tone on");
      wr(ADR_MCTL, 8'h1B);
      chk("loopback", 8'h01, {7'h0, loopback});
      rd(ADR_MSTAT2, 8'hB0, 8'hF0, "loop mirror");
      wr(ADR_MCTL, 8'h09);
      chk("term ready", 8'h01, {7'h0, terminal_ready});
      wr(ADR_MCTL, 8'h08);
      n = 1;
      while (dtr_loss_start !== 1'b1 && n < 60)
      begin
         @(negedge sys_clk);
         n++;
      end
      chk("dtr wait", 8'h01, {7'h0, (n >= LOSS - 1 && n <= LOSS + 2)});
      @(negedge sys_clk);
      chk("dtr single", 8'h00, {7'h0, dtr_loss_start});
      wr(ADR_SCRATCH, 8'h5A);
      wr(ADR_IEN, 8'h0F);
      wr(ADR_MCTL, 8'h0C);
      chk("master reset", 8'h01, {7'h0, master_reset});
      wr(ADR_MCTL, 8'h08);
      rd(ADR_SCRATCH, SCRATCH_RST, 8'hFF, "scratch reset");
      rd(ADR_IEN, 8'h00, 8'hFF, "enable reset");
      rd(ADR_MCTL, 8'h08, 8'hFF, "control kept");
      // Reads and writes that leave this block for the serial section
      chk("ext reads", 8'd20, n_erd[7:0]);
      chk("ext writes", 8'd6, n_ewr[7:0]);
      idle(2);
      report_and_stop();
   end
endmodule
